// ### design/rpm_top.sv
`timescale 1ns/1ps
`include "rpm_defs.svh"
module rpm_top
  import rpm_pkg::*;
#(
  parameter int MS_CYCLES = `RPM_MS_NS / `RPM_CLK_NS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [15:0] rx_orig_id,
  input wire logic [11:0] rx_vlan,
  input wire logic [15:0] rx_appid,
  input wire logic [15:0] rx_ttl_ms,
  input wire logic [127:0] rx_pairs,
  input wire logic dl_valid,
  input wire logic [3:0] dl_src_id,
  input wire logic [31:0] dl_bits,
  input wire logic [15:0] dl_offline,
  input wire logic [63:0] oper,
  output logic tx_valid,
  output logic [15:0] tx_orig_id,
  output logic [1:0] tx_transport,
  output logic [31:0] tx_dna,
  output logic [31:0] tx_userst,
  output logic [31:0] rin,
  output logic [31:0] din,
  output logic [15:0] slot_online
);
  import rpm_pkg::*;

  rpm_top_st_t r_r;
  rpm_top_st_t r_nxt;
  rpm_hold_if hif();
  logic [15:0] restart_c;
  logic tick_c;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic rpm_in_win(input logic [7:0] a,
                                      input logic [7:0] base,
                                      input logic [7:0] size);
    return (a >= base) && (a < base + size);
  endfunction

  function automatic logic rpm_fallback(input logic [1:0] fb,
                                        input logic known,
                                        input logic last);
    logic v;
    v = 1'b0;
    case (rpm_fb_t'(fb))
      RPM_FB_OFF: v = 1'b0;
      RPM_FB_ON: v = 1'b1;
      RPM_FB_HOLD_HI: v = known ? last : 1'b1;
      RPM_FB_HOLD_LO: v = known ? last : 1'b0;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic [5:0] rpm_idle_clamp(input logic [5:0] v);
    logic [5:0] c;
    c = v;
    if (v < `RPM_IDLE_MIN)
      c = `RPM_IDLE_MIN;
    else if (v > `RPM_IDLE_MAX)
      c = `RPM_IDLE_MAX;
    return c;
  endfunction

  // ----------------------------------------------------------------
  // hold timers
  // ----------------------------------------------------------------
  assign hif.restart = restart_c;
  assign hif.ttl_ms = rx_ttl_ms;
  assign hif.tick = tick_c;

  rpm_slot_timer u_tmr (
    .clk (clk),
    .rst (rst),
    .hif (hif)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] dna_c;
    logic [31:0] ust_c;
    logic [3:0] s;
    logic [5:0] b;
    logic on;
    logic v;
    logic sec_tick;
    logic expire;
    logic send;
    logic [4:0] k;
    dna_c = '0;
    ust_c = '0;
    s = 4'h0;
    b = 6'h00;
    on = 1'b0;
    v = 1'b0;
    sec_tick = 1'b0;
    expire = 1'b0;
    send = 1'b0;
    k = 5'h00;
    restart_c = '0;
    r_nxt = r_r;
    r_nxt.rdata = '0;

    // millisecond and second base for timers and idle resend
    tick_c = (r_r.cyc == 16'(MS_CYCLES - 1));
    r_nxt.cyc = tick_c ? 16'h0000 : r_r.cyc + 16'h0001;
    if (tick_c)
    begin
      sec_tick = (r_r.ms == `RPM_MS_PER_S);
      r_nxt.ms = sec_tick ? 10'h000 : r_r.ms + 10'h001;
    end

    // receive: every matching slot takes the odd bit of each of the 64 pairs
    for (int q = 0; q < `RPM_NSLOT; q++)
    begin
      if (rx_valid && rpm_tp_t'(r_r.tp) != RPM_TP_NONE
          && r_r.slot_en[q] && rx_orig_id == r_r.slot_id[q]
          && (rpm_tp_t'(r_r.tp) != RPM_TP_GOOSE
              || (rx_vlan == r_r.slot_vlan[q]
                  && rx_appid == r_r.slot_appid[q])))
      begin
        restart_c[q] = 1'b1;
        for (int p = 0; p < 64; p++)
          r_nxt.slot_dat[q][p] = rx_pairs[2 * p + 1];
      end
    end

    // remote inputs
    for (int i = 0; i < `RPM_NPT; i++)
    begin
      s = r_r.ri_slot[i];
      b = r_r.ri_bit[i];
      on = hif.online[s];
      v = r_r.slot_dat[s][b];
      if (on)
      begin
        r_nxt.ri_last[i] = v;
        r_nxt.ri_known[i] = 1'b1;
        r_nxt.rin[i] = v;
      end
      else
        r_nxt.rin[i] = rpm_fallback(r_r.ri_fb[i], r_r.ri_known[i],
                                    r_r.ri_last[i]);
    end

    // direct inputs
    for (int i = 0; i < `RPM_NPT; i++)
    begin
      s = r_r.di_src[i];
      k = r_r.di_bit[i];
      on = !dl_offline[s];
      if (dl_valid && on && dl_src_id == s)
      begin
        r_nxt.di_last[i] = dl_bits[k];
        r_nxt.di_known[i] = 1'b1;
      end
      if (on && r_nxt.di_known[i])
        r_nxt.din[i] = r_nxt.di_last[i];
      else
        r_nxt.din[i] = rpm_fallback(r_r.di_fb[i], r_r.di_known[i],
                                    r_r.di_last[i]);
    end

    // transmit points and send decision
    for (int i = 0; i < `RPM_NPT; i++)
    begin
      dna_c[i] = oper[r_r.dna_sel[i]];
      ust_c[i] = oper[r_r.ust_sel[i]];
    end
    r_nxt.dna = dna_c;
    r_nxt.ust = ust_c;
    if (sec_tick)
      r_nxt.secs = r_r.secs + 6'h01;
    expire = sec_tick && (r_r.secs + 6'h01 >= r_r.idle_s);
    // no transport means nothing is sent; power-up send stays pending
    send = rpm_tp_t'(r_r.tp) != RPM_TP_NONE
           && (r_r.boot || dna_c != r_r.dna || ust_c != r_r.ust
               || expire);
    r_nxt.tx_valid = send;
    if (send)
    begin
      r_nxt.boot = 1'b0;
      r_nxt.secs = 6'h00;
    end

    // register writes
    if (reg_wr)
    begin
      k = reg_addr[4:0];
      if (reg_addr == `RPM_OFS_CTRL)
      begin
        r_nxt.tp = reg_wdata[`RPM_CTRL_TP];
        r_nxt.idle_s = rpm_idle_clamp(reg_wdata[`RPM_CTRL_IDLE]);
      end
      if (reg_addr == `RPM_OFS_LOCAL_ID)
        r_nxt.local_id = reg_wdata[15:0];
      if (rpm_in_win(reg_addr, `RPM_OFS_SLOT_ID, `RPM_WIN16))
      begin
        r_nxt.slot_id[k[3:0]] = reg_wdata[`RPM_SLOT_ID];
        r_nxt.slot_appid[k[3:0]] = reg_wdata[`RPM_SLOT_APPID];
      end
      if (rpm_in_win(reg_addr, `RPM_OFS_SLOT_NET, `RPM_WIN16))
      begin
        r_nxt.slot_vlan[k[3:0]] = reg_wdata[`RPM_NET_VLAN];
        r_nxt.slot_en[k[3:0]] = reg_wdata[`RPM_NET_EN];
      end
      if (rpm_in_win(reg_addr, `RPM_OFS_RI_CFG, `RPM_WIN32))
      begin
        r_nxt.ri_slot[k] = reg_wdata[`RPM_RI_SLOT];
        r_nxt.ri_bit[k] = reg_wdata[`RPM_RI_BIT];
        r_nxt.ri_fb[k] = reg_wdata[`RPM_RI_FB];
      end
      if (rpm_in_win(reg_addr, `RPM_OFS_DI_CFG, `RPM_WIN32))
      begin
        r_nxt.di_src[k] = reg_wdata[`RPM_DI_SRC];
        r_nxt.di_bit[k] = reg_wdata[`RPM_DI_BIT];
        r_nxt.di_fb[k] = reg_wdata[`RPM_DI_FB];
      end
      if (rpm_in_win(reg_addr, `RPM_OFS_DNA_SEL, `RPM_WIN32))
        r_nxt.dna_sel[k] = reg_wdata[`RPM_SEL];
      if (rpm_in_win(reg_addr, `RPM_OFS_UST_SEL, `RPM_WIN32))
        r_nxt.ust_sel[k] = reg_wdata[`RPM_SEL];
    end

    // register reads, answered in the next cycle; unmapped reads zero
    if (reg_rd)
    begin
      k = reg_addr[4:0];
      if (reg_addr == `RPM_OFS_CTRL)
      begin
        r_nxt.rdata[`RPM_CTRL_TP] = r_r.tp;
        r_nxt.rdata[`RPM_CTRL_IDLE] = r_r.idle_s;
      end
      if (reg_addr == `RPM_OFS_LOCAL_ID)
        r_nxt.rdata[15:0] = r_r.local_id;
      if (reg_addr == `RPM_OFS_ONLINE)
        r_nxt.rdata[15:0] = hif.online;
      if (reg_addr == `RPM_OFS_RIN)
        r_nxt.rdata = r_r.rin;
      if (reg_addr == `RPM_OFS_DIN)
        r_nxt.rdata = r_r.din;
      if (rpm_in_win(reg_addr, `RPM_OFS_SLOT_ID, `RPM_WIN16))
      begin
        r_nxt.rdata[`RPM_SLOT_ID] = r_r.slot_id[k[3:0]];
        r_nxt.rdata[`RPM_SLOT_APPID] = r_r.slot_appid[k[3:0]];
      end
      if (rpm_in_win(reg_addr, `RPM_OFS_SLOT_NET, `RPM_WIN16))
      begin
        r_nxt.rdata[`RPM_NET_VLAN] = r_r.slot_vlan[k[3:0]];
        r_nxt.rdata[`RPM_NET_EN] = r_r.slot_en[k[3:0]];
      end
      if (rpm_in_win(reg_addr, `RPM_OFS_RI_CFG, `RPM_WIN32))
      begin
        r_nxt.rdata[`RPM_RI_SLOT] = r_r.ri_slot[k];
        r_nxt.rdata[`RPM_RI_BIT] = r_r.ri_bit[k];
        r_nxt.rdata[`RPM_RI_FB] = r_r.ri_fb[k];
      end
      if (rpm_in_win(reg_addr, `RPM_OFS_DI_CFG, `RPM_WIN32))
      begin
        r_nxt.rdata[`RPM_DI_SRC] = r_r.di_src[k];
        r_nxt.rdata[`RPM_DI_BIT] = r_r.di_bit[k];
        r_nxt.rdata[`RPM_DI_FB] = r_r.di_fb[k];
      end
      if (rpm_in_win(reg_addr, `RPM_OFS_DNA_SEL, `RPM_WIN32))
        r_nxt.rdata[`RPM_SEL] = r_r.dna_sel[k];
      if (rpm_in_win(reg_addr, `RPM_OFS_UST_SEL, `RPM_WIN32))
        r_nxt.rdata[`RPM_SEL] = r_r.ust_sel[k];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_r <= '0;
      r_r.tp <= `RPM_TP_RST;
      r_r.idle_s <= `RPM_IDLE_RST;
      r_r.boot <= 1'b1;
    end
    else
      r_r <= r_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = r_r.rdata;
  assign tx_valid = r_r.tx_valid;
  assign tx_orig_id = r_r.local_id;
  assign tx_transport = r_r.tp;
  assign tx_dna = r_r.dna;
  assign tx_userst = r_r.ust;
  assign rin = r_r.rin;
  assign din = r_r.din;
  assign slot_online = hif.online;
endmodule // rpm_top

// ### shared/rpm_defs.svh
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define RPM_NSLOT 16
`define RPM_NPT 32

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RPM_OFS_CTRL 8'h00
`define RPM_OFS_LOCAL_ID 8'h01
`define RPM_OFS_ONLINE 8'h02
`define RPM_OFS_RIN 8'h03
`define RPM_OFS_DIN 8'h04
`define RPM_OFS_SLOT_ID 8'h10
`define RPM_OFS_SLOT_NET 8'h20
`define RPM_OFS_RI_CFG 8'h40
`define RPM_OFS_DI_CFG 8'h60
`define RPM_OFS_DNA_SEL 8'h80
`define RPM_OFS_UST_SEL 8'hA0
`define RPM_WIN16 8'h10
`define RPM_WIN32 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RPM_CTRL_TP 1:0
`define RPM_CTRL_IDLE 13:8
`define RPM_SLOT_ID 15:0
`define RPM_SLOT_APPID 31:16
`define RPM_NET_VLAN 11:0
`define RPM_NET_EN 12
`define RPM_RI_SLOT 3:0
`define RPM_RI_BIT 9:4
`define RPM_RI_FB 13:12
`define RPM_DI_SRC 3:0
`define RPM_DI_BIT 8:4
`define RPM_DI_FB 13:12
`define RPM_SEL 5:0

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define RPM_TP_RST 2'h1
`define RPM_IDLE_RST 6'h3C
`define RPM_IDLE_MIN 6'h01
`define RPM_IDLE_MAX 6'h3C

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RPM_CLK_NS 20
`define RPM_MS_NS 1000000
`define RPM_MS_PER_S 10'h3E7

`endif

// ### shared/rpm_pkg.sv
package rpm_pkg;
  `include "rpm_defs.svh"

  typedef enum logic [1:0] {
    RPM_TP_NONE = 2'h0,
    RPM_TP_GSSE = 2'h1,
    RPM_TP_GOOSE = 2'h2
  } rpm_tp_t;

  typedef enum logic [1:0] {
    RPM_FB_OFF = 2'h0,
    RPM_FB_ON = 2'h1,
    RPM_FB_HOLD_HI = 2'h2,
    RPM_FB_HOLD_LO = 2'h3
  } rpm_fb_t;

  typedef struct packed {
    logic [15:0][15:0] cnt;
  } rpm_tmr_st_t;

  typedef struct packed {
    logic [1:0] tp;
    logic [5:0] idle_s;
    logic [15:0] local_id;
    logic [15:0] slot_en;
    logic [15:0][15:0] slot_id;
    logic [15:0][15:0] slot_appid;
    logic [15:0][11:0] slot_vlan;
    logic [15:0][63:0] slot_dat;
    logic [31:0][3:0] ri_slot;
    logic [31:0][5:0] ri_bit;
    logic [31:0][1:0] ri_fb;
    logic [31:0] ri_last;
    logic [31:0] ri_known;
    logic [31:0] rin;
    logic [31:0][3:0] di_src;
    logic [31:0][4:0] di_bit;
    logic [31:0][1:0] di_fb;
    logic [31:0] di_last;
    logic [31:0] di_known;
    logic [31:0] din;
    logic [31:0][5:0] dna_sel;
    logic [31:0][5:0] ust_sel;
    logic [31:0] dna;
    logic [31:0] ust;
    logic tx_valid;
    logic boot;
    logic [15:0] cyc;
    logic [9:0] ms;
    logic [5:0] secs;
    logic [31:0] rdata;
  } rpm_top_st_t;
endpackage

// ### shared/rpm_hold_if.sv
`timescale 1ns/1ps
interface rpm_hold_if;
  logic [15:0] restart;
  logic [15:0] ttl_ms;
  logic tick;
  logic [15:0] online;
  modport owner (output restart, output ttl_ms, output tick, input online);
  modport timer (input restart, input ttl_ms, input tick, output online);
endinterface

// ### design/rpm_slot_timer.sv
`timescale 1ns/1ps
`include "rpm_defs.svh"
// ----------------------------------------------------------------
// per-slot hold timers, counted in milliseconds
// ----------------------------------------------------------------
module rpm_slot_timer
  import rpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  rpm_hold_if.timer hif
);
  rpm_tmr_st_t r_r;
  rpm_tmr_st_t r_nxt;

  always_comb
  begin
    r_nxt = r_r;
    for (int s = 0; s < `RPM_NSLOT; s++)
    begin
      // a restart in the tick cycle wins, so a fresh message is never lost
      if (hif.restart[s])
        r_nxt.cnt[s] = hif.ttl_ms;
      else if (hif.tick && r_r.cnt[s] != 16'h0000)
        r_nxt.cnt[s] = r_r.cnt[s] - 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  // zero count is offline; reset starts all slots offline
  generate
    for (genvar g = 0; g < `RPM_NSLOT; g++)
    begin : g_on
      assign hif.online[g] = (r_r.cnt[g] != 16'h0000);
    end
  endgenerate
endmodule // rpm_slot_timer

// ### bench/rpm_chk.sv
`timescale 1ns/1ps
module rpm_chk
  import rpm_pkg::*;
#(
  parameter int MS_CYCLES = 10
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic dl_valid,
  input wire logic [15:0] dl_offline,
  input wire logic tx_valid,
  input wire logic [15:0] tx_orig_id,
  input wire logic [1:0] tx_transport,
  input wire logic [31:0] din,
  input wire logic [15:0] slot_online
);
  import rpm_pkg::*;
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // one spare second: the idle count rides a free-running second base
  // wide count: the full-rate millisecond base overflows a plain int
  localparam longint IDLE_LIM = longint'(61) * 1000 * MS_CYCLES;
  longint quiet_r;
  logic poke;
  assign poke = reg_wr | rst;
  always_ff @(posedge clk)
  begin
    if (rst || tx_valid || tx_transport == RPM_TP_NONE)
      quiet_r <= 0;
    else
      quiet_r <= quiet_r + 1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_id_wr;
    reg_wr && reg_addr == 8'h01;
  endsequence
  sequence s_new_online;
    (slot_online & ~$past(slot_online)) != 16'h0;
  endsequence
  a_orig_id: assert property (
    s_id_wr |-> ##2 tx_orig_id == $past(reg_wdata[15:0], 2))
    else $error("originator id not sent");
  a_tx_mode: assert property (
    tx_valid |-> tx_transport != RPM_TP_NONE)
    else $error("send with no transport");
  a_rd_gap: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_rd_unmapped: assert property (
    reg_rd && reg_addr == 8'h05 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_online_cause: assert property (
    s_new_online |-> $past(rx_valid))
    else $error("slot online without message");
  a_din_cause: assert property (
    !$stable(din) |-> $past(dl_valid) || $past(poke) || $past(poke, 2)
    || $past(dl_offline) != $past(dl_offline, 2))
    else $error("direct input moved without cause");
  a_none_quiet: assert property (
    rx_valid && tx_transport == RPM_TP_NONE
    |=> (slot_online & ~$past(slot_online)) == 16'h0)
    else $error("message taken with no transport");
  a_idle_bound: assert property (quiet_r <= IDLE_LIM)
    else $error("idle resend overdue");
endmodule // rpm_chk

bind rpm_top rpm_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.*);

// ### bench/rpm_peer.sv
`timescale 1ns/1ps
module rpm_peer (
  input wire logic clk,
  output logic rx_valid,
  output logic [15:0] rx_orig_id,
  output logic [11:0] rx_vlan,
  output logic [15:0] rx_appid,
  output logic [15:0] rx_ttl_ms,
  output logic [127:0] rx_pairs
);
  initial
  begin
    rx_valid = 1'b0;
    rx_orig_id = 16'h0;
    rx_vlan = 12'h0;
    rx_appid = 16'h0;
    rx_ttl_ms = 16'h0;
    rx_pairs = 128'h0;
  end
  // one state message per call, whenever the scene says a point moved
  task automatic send(input logic [15:0] id, input logic [11:0] vl,
    input logic [15:0] ap, input logic [15:0] ttl,
    input logic [127:0] pr);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_orig_id <= id;
    rx_vlan <= vl;
    rx_appid <= ap;
    rx_ttl_ms <= ttl;
    rx_pairs <= pr;
    @(posedge clk);
    rx_valid <= 1'b0;
    // stale fields except rx_ttl_ms are inverted so nothing leans on old values
    rx_orig_id <= ~id;
    rx_vlan <= ~vl;
    rx_appid <= ~ap;
    rx_pairs <= ~pr;
  endtask
endmodule // rpm_peer

// ### bench/tb_remote_point_state_mapper.sv
`timescale 1ns/1ps
module tb_remote_point_state_mapper;
  import rpm_pkg::*;
  logic clk, rst, reg_wr, reg_rd, dl_valid, tx_valid, rx_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, dl_bits, tx_dna, tx_userst, rin, din;
  logic [3:0] dl_src_id;
  logic [15:0] dl_offline, tx_orig_id, slot_online;
  logic [15:0] rx_orig_id, rx_appid, rx_ttl_ms;
  logic [11:0] rx_vlan;
  logic [127:0] rx_pairs, pr;
  logic [63:0] oper;
  logic [1:0] tx_transport;
  int n_mismatch, cmp_count, t;
  rpm_top #(.MS_CYCLES(10)) i_dut (.*);
  rpm_peer i_peer (.*);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wait_tx(input int lim);
    t = 0;
    do
    begin
      @(posedge clk);
      #1 t++;
    end while (tx_valid !== 1'b1 && t < lim);
  endtask
  task dl_send(input logic [3:0] s, input logic [31:0] b);
    @(posedge clk);
    dl_valid <= 1'b1;
    dl_src_id <= s;
    dl_bits <= b;
    @(posedge clk);
    dl_valid <= 1'b0;
    dl_bits <= ~b;
    cyc(1);
  endtask
  task end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_boot;
    wait_tx(6);
    chk("boot_tx", 32'h1, tx_valid);
    chk("tx_transport", 32'h1, tx_transport);
    rd(8'h00, 32'h3C01);
    rd(8'h05, 32'h0);
    wr(8'h01, 32'hA5C3);
  endtask
  task t_remote;
    pr = 128'h0000_0000_0000_0026_0000_0000_0000_0009;
    wr(8'h13, 32'h0077_1234);
    wr(8'h23, 32'h1005);
    wr(8'h15, 32'h0077_2222);
    wr(8'h25, 32'h1005);
    wr(8'h40, 32'h2213);
    wr(8'h41, 32'h1003);
    wr(8'h42, 32'h0013);
    cyc(2);
    chk("rin_start", 32'h3, rin[2:0]);
    i_peer.send(16'h1235, 12'h005, 16'h77, 16'h2, pr);
    cyc(3);
    chk("online_foreign", 32'h0, slot_online);
    i_peer.send(16'h1234, 12'h009, 16'h0, 16'h2, pr);
    cyc(3);
    chk("online_gsse", 32'h8, slot_online);
    chk("rin_rx", 32'h4, rin[2:0]);
    cyc(40);
    chk("online_lost", 32'h0, slot_online);
    chk("rin_lost", 32'h2, rin[2:0]);
    i_peer.send(16'h1234, 12'h0, 16'h0, 16'h64, pr | (128'h8 << 64));
    cyc(3);
    chk("rin_back", 32'h5, rin[2:0]);
    wr(8'h00, 32'h3C00);
    i_peer.send(16'h2222, 12'h005, 16'h77, 16'h64, pr);
    cyc(3);
    chk("online_none", 32'h0, slot_online[5]);
    wr(8'h00, 32'h3C02);
    i_peer.send(16'h2222, 12'h009, 16'h77, 16'h64, pr);
    i_peer.send(16'h2222, 12'h005, 16'h78, 16'h64, pr);
    cyc(3);
    chk("online_goose_bad", 32'h0, slot_online[5]);
    i_peer.send(16'h2222, 12'h005, 16'h77, 16'h64, pr);
    cyc(3);
    chk("online_goose", 32'h1, slot_online[5]);
  endtask
  task t_direct;
    wr(8'h60, 32'h3072);
    wr(8'h61, 32'h1082);
    cyc(2);
    chk("din_start", 32'h2, din[1:0]);
    dl_send(4'h2, 32'h80);
    chk("din_rx", 32'h1, din[1:0]);
    dl_send(4'h3, 32'h100);
    chk("din_other", 32'h1, din[1:0]);
    @(posedge clk);
    dl_offline <= 16'h4;
    cyc(2);
    chk("din_off", 32'h3, din[1:0]);
    dl_send(4'h2, 32'h0);
    chk("din_off_rx", 32'h3, din[1:0]);
    @(posedge clk);
    dl_offline <= 16'h0;
  endtask
  task t_tx;
    wr(8'h80, 32'h5);
    wr(8'hBF, 32'h28);
    cyc(2);
    @(posedge clk);
    oper <= 64'h20;
    wait_tx(4);
    chk("tx_chg", 32'h1, tx_valid);
    chk("tx_dna", 32'h1, tx_dna);
    chk("tx_orig_id", 32'hA5C3, tx_orig_id);
    @(posedge clk);
    oper <= 64'h0000_0100_0000_0020;
    wait_tx(4);
    chk("tx_userst", 32'h8000_0000, tx_userst);
  endtask
  task t_idle;
    wr(8'h00, 32'h0001);
    rd(8'h00, 32'h0101);
    wait_tx(21000);
    wait_tx(21000);
    chk("idle_gap", 32'h1, 32'(t > 5000 && t < 10010));
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    dl_valid = 1'b0;
    dl_src_id = 4'h0;
    dl_bits = 32'h0;
    dl_offline = 16'h0;
    oper = 64'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_boot;
    t_remote;
    t_direct;
    t_tx;
    t_idle;
    end_sim;
  end
  initial
  begin
    #1500000;
    n_mismatch++;
    end_sim;
  end
endmodule // tb_remote_point_state_mapper
